// ==== include/asp_defines.vh ====
`ifndef ASP_DEFINES_VH
`define ASP_DEFINES_VH

// Register addresses on the register access port
`define ASP_ADDR_IFCFGA 8'h00
`define ASP_ADDR_OFS0 8'h16
`define ASP_ADDR_OFS1 8'h17
`define ASP_ADDR_OFS2 8'h18
`define ASP_ADDR_GAIN_A 8'h1C
`define ASP_ADDR_GAIN_B 8'h1D
`define ASP_ADDR_MODES 8'h20
`define ASP_ADDR_AVG 8'h21
`define ASP_ADDR_TP0 8'h30
`define ASP_ADDR_TP1 8'h31
`define ASP_ADDR_TP2 8'h32
`define ASP_ADDR_TP3 8'h33
`define ASP_ADDR_DIAG 8'h34

// Field positions
`define ASP_SRST_A_BIT 7
`define ASP_SRST_B_BIT 0
`define ASP_DIAG_RSEEN_BIT 0
`define ASP_DIAG_OVF_BIT 1

// Reset values
`define ASP_GAIN_RST 16'h8000
`define ASP_OFS_RST 24'h000000
`define ASP_TP_RST 32'h5A5A0F0F
`define ASP_AVG_RST 5'h00
`define ASP_FMT_RST 3'h0

// Output format selector codes
`define ASP_FMT_D24 3'h0
`define ASP_FMT_D16CM 3'h1
`define ASP_FMT_D24CM 3'h2
`define ASP_FMT_AVG 3'h3
`define ASP_FMT_TEST 3'h4

// Averaging exponent limits and fixed-point scaling
`define ASP_AVG_MIN 5'h01
`define ASP_AVG_MAX 5'h10
`define ASP_AVG_FRAC 6

// Saturation limits of the 24-bit difference code
`define ASP_D24_MAX 24'h7FFFFF
`define ASP_D24_MIN 24'h800000

// Timing
`define ASP_CLK_MHZ 200
`define ASP_QUIET_US 750
// 750 us at 200 MHz, sized to the 18-bit quiet counter
`define ASP_QUIET_CYC 18'h249F0
`define ASP_RST_PW_NS 50
`define ASP_RST_PW_CYC ((`ASP_RST_PW_NS * `ASP_CLK_MHZ + 999) / 1000)

// Output buffer shape
`define ASP_FIFO_W 32
`define ASP_FIFO_D 8
`define ASP_FIFO_AW 3

`endif

// ==== verilog/asp_top.v ====
`timescale 1ns/10ps
`include "asp_defines.vh"

////////////////////////////////////////////////////////////////////////////
// Output word buffer, flip-flop storage indexed by pointers
module asp_fifo #(
  parameter WIDTH = `ASP_FIFO_W,
  parameter DEPTH = `ASP_FIFO_D,
  parameter AW = `ASP_FIFO_AW
) (
  input wire clk_sys,
  input wire rst_n,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words
  reg [AW-1:0] wr_ptr; // Next slot to fill
  reg [AW-1:0] rd_ptr; // Oldest slot
  reg [AW:0] count; // Words held
  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign level = count;

  // Data words carry no reset; only the pointers and the count need a defined state
  always @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointer and fill count update
  always @(posedge clk_sys) begin
    if (!rst_n || flush) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                  wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                  rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// Sample post-processing and device reset logic
module asp_top #(
  parameter [17:0] QUIET_CYCLES = `ASP_QUIET_CYC
) (
  input wire clk_sys,
  input wire rst_n,
  input wire convert_strobe,
  input wire [23:0] sample_diff,
  input wire [7:0] sample_cm,
  input wire sample_clipped,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg convert_ready,
  output reg quiet_busy,
  output reg out_valid,
  input wire out_ready,
  output reg [31:0] out_word
);
  ////////////////////////////////////////////////////////////////////////
  // Functions

  // True when a 27-bit value fits the 24-bit signed range
  function asp_fits24;
    input [26:0] v;
    begin
      asp_fits24 = (v[26:23] == 4'h0) || (v[26:23] == 4'hF);
    end
  endfunction

  // Clamp a 27-bit signed value to the 24-bit range
  function [23:0] asp_sat24;
    input [26:0] v;
    begin
      if (asp_fits24(v)) begin
        asp_sat24 = v[23:0];
      end else if (v[26]) begin
        asp_sat24 = `ASP_D24_MIN;
      end else begin
        asp_sat24 = `ASP_D24_MAX;
      end
    end
  endfunction

  // Last sample index of a block of 2^n
  function [15:0] asp_blk_last;
    input [4:0] n;
    reg [16:0] one_sh;
    begin
      one_sh = 17'h00001 << n;
      asp_blk_last = one_sh[15:0] - 16'h0001;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Configuration and status registers
  reg [23:0] ofs; // Signed offset
  reg [15:0] gain; // Unsigned gain, 0x8000 is unity
  reg [2:0] fmt; // output_format_select
  reg [4:0] average_exponent; // Block length exponent N
  reg [31:0] tpat; // Test pattern
  reg reset_seen_flag; // Sticky, write one to clear
  reg ovf_flag; // Sticky, a word was lost to a full buffer
  reg soft_pend; // One-cycle soft reset request
  reg [17:0] quiet_cnt; // Cycles left in the post-reset quiet period

  wire cfg_rst = !rst_n || soft_pend; // Clears configuration and datapath
  wire quiet = (quiet_cnt != 18'h00000);
  wire wr_ok = reg_wr && !quiet; // Writes are refused while quiet
  wire soft_reset_bit_a = reg_wdata[`ASP_SRST_A_BIT];
  wire soft_reset_bit_b = reg_wdata[`ASP_SRST_B_BIT];

  // Both soft reset bits must arrive in the same write
  wire soft_hit = wr_ok && (reg_addr == `ASP_ADDR_IFCFGA) &&
                  soft_reset_bit_a && soft_reset_bit_b;

  // Soft reset request; it acts on the cycle after the write
  always @(posedge clk_sys) begin
    if (!rst_n || soft_pend) begin
      soft_pend <= 1'b0;
    end else begin
      soft_pend <= soft_hit;
    end
  end

  // Quiet period after either reset blocks conversions and writes
  always @(posedge clk_sys) begin
    if (cfg_rst) begin
      quiet_cnt <= QUIET_CYCLES;
    end else if (quiet) begin
      quiet_cnt <= quiet_cnt - 18'h00001;
    end
  end

  // User configuration registers, defaults after any reset
  always @(posedge clk_sys) begin
    if (cfg_rst) begin
      ofs <= `ASP_OFS_RST;
      gain <= `ASP_GAIN_RST;
      fmt <= `ASP_FMT_RST;
      average_exponent <= `ASP_AVG_RST;
      tpat <= `ASP_TP_RST;
    end else if (wr_ok) begin
      case (reg_addr)
        `ASP_ADDR_OFS0: ofs[7:0] <= reg_wdata;
        `ASP_ADDR_OFS1: ofs[15:8] <= reg_wdata;
        `ASP_ADDR_OFS2: ofs[23:16] <= reg_wdata;
        `ASP_ADDR_GAIN_A: gain[7:0] <= reg_wdata;
        `ASP_ADDR_GAIN_B: gain[15:8] <= reg_wdata;
        `ASP_ADDR_MODES: fmt <= reg_wdata[2:0];
        `ASP_ADDR_AVG: average_exponent <= reg_wdata[4:0];
        `ASP_ADDR_TP0: tpat[7:0] <= reg_wdata;
        `ASP_ADDR_TP1: tpat[15:8] <= reg_wdata;
        `ASP_ADDR_TP2: tpat[23:16] <= reg_wdata;
        `ASP_ADDR_TP3: tpat[31:24] <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Diagnostic clear strobes; a set in the same cycle wins
  wire diag_wr = wr_ok && (reg_addr == `ASP_ADDR_DIAG);
  wire clr_rseen = diag_wr && reg_wdata[`ASP_DIAG_RSEEN_BIT];
  wire clr_ovf = diag_wr && reg_wdata[`ASP_DIAG_OVF_BIT];
  wire ovf_set; // Driven by the output stage below

  // Reset-seen flag: set by every reset, cleared only by writing one
  always @(posedge clk_sys) begin
    if (cfg_rst) begin
      reset_seen_flag <= 1'b1;
    end else if (clr_rseen) begin
      reset_seen_flag <= 1'b0;
    end
  end

  // Lost-word flag; soft reset leaves it, a hard reset or writing one clears it
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ovf_flag <= 1'b0;
    end else if (ovf_set) begin
      ovf_flag <= 1'b1;
    end else if (clr_ovf) begin
      ovf_flag <= 1'b0;
    end
  end

  // Register read data, one cycle after the read strobe
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ASP_ADDR_OFS0: reg_rdata <= ofs[7:0];
        `ASP_ADDR_OFS1: reg_rdata <= ofs[15:8];
        `ASP_ADDR_OFS2: reg_rdata <= ofs[23:16];
        `ASP_ADDR_GAIN_A: reg_rdata <= gain[7:0];
        `ASP_ADDR_GAIN_B: reg_rdata <= gain[15:8];
        `ASP_ADDR_MODES: reg_rdata <= {5'h00, fmt};
        `ASP_ADDR_AVG: reg_rdata <= {3'h0, average_exponent};
        `ASP_ADDR_TP0: reg_rdata <= tpat[7:0];
        `ASP_ADDR_TP1: reg_rdata <= tpat[15:8];
        `ASP_ADDR_TP2: reg_rdata <= tpat[23:16];
        `ASP_ADDR_TP3: reg_rdata <= tpat[31:24];
        `ASP_ADDR_DIAG: reg_rdata <= {6'h00, ovf_flag, reset_seen_flag};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stage 1: gain, offset, saturation
  // Gain goes first so the offset is in output codes, not input codes
  wire signed [23:0] s_in = sample_diff;
  wire signed [16:0] g_s = {1'b0, gain};
  wire signed [40:0] prod = s_in * g_s;
  wire [25:0] scaled = prod[40:15]; // Divide by 0x8000
  wire [26:0] with_ofs = {scaled[25], scaled} +
                         {{3{ofs[23]}}, ofs};
  wire take = convert_strobe && convert_ready && !quiet;

  reg p_valid; // Stage 1 result present
  reg [23:0] p_d24; // Processed difference code
  reg [7:0] p_cm; // Common-mode code, passed through
  reg p_or; // Sample saturated, analog or numeric

  // Stage 1 register
  always @(posedge clk_sys) begin
    if (cfg_rst) begin
      p_valid <= 1'b0;
      p_d24 <= 24'h000000;
      p_cm <= 8'h00;
      p_or <= 1'b0;
    end else begin
      p_valid <= take;
      if (take) begin
        p_d24 <= asp_sat24(with_ofs);
        p_cm <= sample_cm;
        p_or <= sample_clipped || !asp_fits24(with_ofs);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stage 2: block averaging and word formatting
  wire avg_on = (fmt == `ASP_FMT_AVG) &&
                (average_exponent >= `ASP_AVG_MIN) &&
                (average_exponent <= `ASP_AVG_MAX);
  reg signed [39:0] acc; // Block sum
  reg [15:0] blk_cnt; // Samples taken in this block
  reg blk_or; // Any saturation earlier in this block

  wire blk_end = (blk_cnt == asp_blk_last(average_exponent));
  wire signed [39:0] total = acc + {{16{p_d24[23]}}, p_d24};
  wire signed [45:0] tot_fx = {total, {`ASP_AVG_FRAC{1'b0}}};
  // Scaling by 2^6 / 2^N keeps a constant input in the top 24 bits
  wire signed [45:0] avg_fx = tot_fx >>> average_exponent;
  wire [29:0] avg30 = avg_fx[29:0];

  // Accumulator, cleared at the end of every block
  always @(posedge clk_sys) begin
    if (cfg_rst || !avg_on) begin
      acc <= 40'sh0000000000;
      blk_cnt <= 16'h0000;
      blk_or <= 1'b0;
    end else if (p_valid) begin
      if (blk_end) begin
        acc <= 40'sh0000000000;
        blk_cnt <= 16'h0000;
        blk_or <= 1'b0;
      end else begin
        acc <= total;
        blk_cnt <= blk_cnt + 16'h0001;
        blk_or <= blk_or || p_or;
      end
    end
  end

  reg [31:0] word; // Formatted word, written whole into the buffer
  reg push; // Word ready for the buffer this cycle

  // Output format selection
  always @* begin
    word = {8'h00, p_d24};
    push = p_valid;
    case (fmt)
      `ASP_FMT_D16CM: word = {8'h00, p_d24[23:8], p_cm};
      `ASP_FMT_D24CM: word = {p_d24, p_cm};
      `ASP_FMT_AVG: begin
        if (avg_on) begin
          // Flags sit in the two lowest bits
          word = {avg30, blk_or || p_or, 1'b1};
          push = p_valid && blk_end;
        end
      end
      `ASP_FMT_TEST: word = tpat;
      default: word = {8'h00, p_d24};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Output buffer and registered output stage
  wire f_in_ready;
  wire f_out_valid;
  wire [31:0] f_out_data;
  wire [3:0] f_level;
  wire load_out = !out_valid || out_ready;

  assign ovf_set = push && !f_in_ready;

  asp_fifo #(
    .WIDTH(`ASP_FIFO_W),
    .DEPTH(`ASP_FIFO_D),
    .AW(`ASP_FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .flush(soft_pend),
    .in_valid(push),
    .in_ready(f_in_ready),
    .in_data(word),
    .out_valid(f_out_valid),
    .out_ready(load_out),
    .out_data(f_out_data),
    .level(f_level)
  );

  // Output register; holds its word until the reader takes it
  always @(posedge clk_sys) begin
    if (cfg_rst) begin
      out_valid <= 1'b0;
      out_word <= 32'h00000000;
    end else if (load_out) begin
      out_valid <= f_out_valid;
      if (f_out_valid) begin
        out_word <= f_out_data;
      end
    end
  end

  // Conversion acceptance; three slots kept for words in flight,
  // so back-pressure stops new samples before any can be lost
  always @(posedge clk_sys) begin
    if (cfg_rst) begin
      convert_ready <= 1'b0;
      quiet_busy <= 1'b1;
    end else begin
      convert_ready <= !quiet && (f_level <= 4'h5);
      quiet_busy <= quiet;
    end
  end
endmodule

// ==== bench/asp_host_reader.sv ====
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
// Host side reader of result words; it can stall on command
module asp_host_reader (
  input wire clk_sys,
  input wire rst_n,
  input wire stall,
  input wire out_valid,
  input wire [31:0] out_word,
  output reg out_ready,
  output reg got,
  output reg [31:0] got_word
);
  // Ready follows the stall request one edge late, like a slow host
  // Words are taken whole, all 32 bits in parallel on the handshake edge
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      out_ready <= 1'b0;
      got <= 1'b0;
      got_word <= 32'h00000000;
    end else begin
      out_ready <= !stall;
      got <= out_valid && out_ready;
      got_word <= out_word;
    end
  end
endmodule

// ==== bench/asp_checker.sv ====
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
// Timing checks on the ports of the post-processing block
module asp_checker #(
  parameter [17:0] QUIET_CYCLES = 18'h00014
) (
  input wire clk_sys,
  input wire rst_n,
  input wire convert_strobe,
  input wire [23:0] sample_diff,
  input wire [7:0] sample_cm,
  input wire sample_clipped,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire convert_ready,
  input wire quiet_busy,
  input wire out_valid,
  input wire out_ready,
  input wire [31:0] out_word
);
  reg [18:0] qcnt; // Cycles seen inside the quiet period
  reg [2:0] fmt_sh; // Shadow of the format selector

  // Quiet counter restarts whenever the quiet period is over
  always @(posedge clk_sys) begin
    if (!rst_n || !quiet_busy) begin
      qcnt <= 19'h00000;
    end else begin
      qcnt <= qcnt + 19'h00001;
    end
  end

  // Shadow format; cleared while quiet since any reset clears it
  always @(posedge clk_sys) begin
    if (!rst_n || quiet_busy) begin
      fmt_sh <= 3'h0;
    end else if (reg_wr && reg_addr == 8'h20) begin
      fmt_sh <= reg_wdata[2:0];
    end
  end

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_quiet_blocks_convert: assert property (quiet_busy |-> !convert_ready)
    else $error("convert ready during quiet period");
  a_reset_leaves_quiet: assert property ($rose(rst_n) |->
    quiet_busy && !out_valid && reg_rdata == 8'h00)
    else $error("state after hard reset wrong");
  a_quiet_exact_span: assert property ($fell(quiet_busy) |->
    qcnt == {1'b0, QUIET_CYCLES} + 19'h00001)
    else $error("quiet period length wrong");
  a_ready_after_quiet: assert property ($fell(quiet_busy) |->
    ##[0:1] convert_ready)
    else $error("convert ready late after quiet");
  a_soft_both_bits: assert property (reg_wr && reg_addr == 8'h00 &&
    reg_wdata[7] && reg_wdata[0] && !quiet_busy |-> ##[1:3] quiet_busy)
    else $error("soft reset did not start");
  a_soft_one_bit: assert property (reg_wr && reg_addr == 8'h00 &&
    (reg_wdata[7] ^ reg_wdata[0]) && !quiet_busy |=> !quiet_busy [*3])
    else $error("single bit caused a reset");
  a_strobe_gives_word: assert property (convert_strobe && convert_ready &&
    !out_valid && fmt_sh != 3'h3 && !reg_wr && !$past(reg_wr)
    |-> ##[1:3] out_valid)
    else $error("no word after accepted strobe");
  a_word_holds: assert property (out_valid && !out_ready && !reg_wr &&
    !$past(reg_wr) |=> out_valid && $stable(out_word))
    else $error("result word changed while stalled");
endmodule

bind asp_top asp_checker #(.QUIET_CYCLES(QUIET_CYCLES)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .convert_strobe(convert_strobe),
  .sample_diff(sample_diff), .sample_cm(sample_cm),
  .sample_clipped(sample_clipped), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .convert_ready(convert_ready), .quiet_busy(quiet_busy),
  .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word));

// ==== bench/testbench.sv ====
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
// Register and sample path tests of the post-processing block
module testbench;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg convert_strobe = 1'b0;
  reg [23:0] sample_diff = 24'h000000;
  reg [7:0] sample_cm = 8'h00;
  reg sample_clipped = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [7:0] reg_wdata = 8'h00;
  reg stall = 1'b0; // Makes the reader hold off
  wire [7:0] reg_rdata;
  wire convert_ready, quiet_busy, out_valid, out_ready, got;
  wire [31:0] out_word, got_word;
  integer miscompares = 0;
  integer samples_checked = 0;
  integer i;
  reg [31:0] q[$]; // Words expected from the buffer, oldest first
  // Reset-value table: address and expected byte, first entry on top
  localparam [95:0] RA = 96'h1C1D21161718303132333437;
  localparam [95:0] RE = 96'h008000000000_0F0F5A5A0100;
  localparam [95:0] AV = 96'h000001000002000003000006;

  always #2.5 clk_sys = ~clk_sys;

  asp_top #(.QUIET_CYCLES(18'h00014)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .convert_strobe(convert_strobe), .sample_diff(sample_diff),
    .sample_cm(sample_cm), .sample_clipped(sample_clipped),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .convert_ready(convert_ready), .quiet_busy(quiet_busy),
    .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word));
  asp_host_reader host (.clk_sys(clk_sys), .rst_n(rst_n), .stall(stall),
    .out_valid(out_valid), .out_word(out_word), .out_ready(out_ready),
    .got(got), .got_word(got_word));

  // Inputs change 1 ns after the edge so the design never races them
  task tick;
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask

  task check(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // A spare edge after each strobe keeps calls from colliding
  task wr(input [7:0] a, input [7:0] d);
    begin
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick;
      reg_wr = 1'b0;
      tick;
    end
  endtask

  // Read data is valid one edge after the strobe is taken
  task rchk(input [7:0] a, input [7:0] exp);
    begin
      reg_addr = a;
      reg_rd = 1'b1;
      tick;
      reg_rd = 0;
      check("reg_rdata", {24'h000000, reg_rdata}, {24'h000000, exp});
      tick;
    end
  endtask

  // Bounded wait: a stuck ready counts as a miscompare after 100 cycles
  task strobe(input [23:0] d, input [7:0] cm, input clip);
    integer k;
    begin
      k = 0;
      while (convert_ready !== 1'b1 && k < 100) begin
        tick;
        k = k + 1;
      end
      if (k >= 100) miscompares = miscompares + 1;
      sample_diff = d;
      sample_cm = cm;
      sample_clipped = clip;
      convert_strobe = 1'b1;
      tick;
      convert_strobe = 1'b0;
      tick;
    end
  endtask

  task take(input [31:0] exp);
    integer k;
    begin
      k = 0;
      tick;
      while (got !== 1'b1 && k < 100) begin
        tick;
        k = k + 1;
      end
      if (k >= 100) miscompares = miscompares + 1;
      check("out_word", got_word, exp);
    end
  endtask

  task end_of_test;
    begin
      $display("checks %0d miscompares %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask

  // Watchdog: the tests need a few thousand cycles at most
  initial begin
    #100000;
    miscompares = miscompares + 1;
    end_of_test;
  end

  // Main sequence
  initial begin
    // Supplies count as settled at time zero; reset held past 50 ns
    repeat (11) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    wr(8'h21, 8'h05); // Lands in the quiet period, must be dropped
    strobe(24'h123456, 8'h00, 1'b0);
    take(32'h00123456);
    for (i = 0; i < 12; i = i + 1) begin
      rchk(RA[95-8*i -: 8], RE[95-8*i -: 8]);
    end
    wr(8'h34, 8'h00);
    rchk(8'h34, 8'h01);
    wr(8'h34, 8'h01);
    rchk(8'h34, 8'h00);
    // Stall the reader, overfill the buffer, then drain it in order
    stall = 1'b1;
    for (i = 0; i < 10; i = i + 1) begin
      if (convert_ready === 1'b1) q.push_back(32'h00000A00 + i);
      sample_diff = 24'h000A00 + i;
      convert_strobe = 1'b1;
      tick;
      convert_strobe = 1'b0;
      tick;
    end
    check("refused", {31'h00000000, q.size() < 10}, 32'h00000001);
    stall = 1'b0;
    while (q.size() > 0) take(q.pop_front());
    wr(8'h1D, 8'h40);
    wr(8'h16, 8'h10);
    strobe(24'h000100, 8'h00, 1'b0);
    take(32'h00000090);
    wr(8'h1C, 8'hFF);
    wr(8'h1D, 8'hFF);
    wr(8'h16, 8'h00);
    strobe(24'h7FFFFF, 8'h00, 1'b0);
    take(32'h007FFFFF);
    strobe(24'h800000, 8'h00, 1'b0);
    take(32'h00800000);
    wr(8'h1C, 8'h00);
    wr(8'h1D, 8'h80);
    wr(8'h20, 8'h01);
    strobe(24'h123456, 8'hA5, 1'b0);
    take(32'h001234A5);
    wr(8'h20, 8'h02);
    strobe(24'h123456, 8'hA5, 1'b0);
    take(32'h123456A5);
    wr(8'h20, 8'h04);
    strobe(24'h000001, 8'h00, 1'b0);
    take(32'h5A5A0F0F);
    for (i = 0; i < 4; i = i + 1) wr(8'h30 + i, 8'h78 - 8'h22 * i);
    strobe(24'h000001, 8'h00, 1'b0);
    take(32'h12345678);
    // Averaging over blocks of four, then two, then two bad exponents
    wr(8'h21, 8'h02);
    wr(8'h20, 8'h03);
    for (i = 0; i < 4; i = i + 1) strobe(AV[95-24*i -: 24], 8'h00, 1'b0);
    take(32'h00000301);
    for (i = 0; i < 4; i = i + 1) strobe(24'h000010, 8'h00, i == 1);
    take(32'h00001003);
    wr(8'h21, 8'h01);
    for (i = 0; i < 2; i = i + 1) strobe(24'h000100 + 2 * i, 8'h00, 1'b0);
    take(32'h00010101);
    wr(8'h21, 8'h00);
    strobe(24'h000654, 8'h00, 1'b0);
    take(32'h00000654);
    wr(8'h21, 8'h11);
    strobe(24'h000321, 8'h00, 1'b0);
    take(32'h00000321);
    // One soft reset bit at a time does nothing; both together reset
    wr(8'h00, 8'h80);
    wr(8'h00, 8'h01);
    rchk(8'h21, 8'h11);
    wr(8'h00, 8'h81);
    check("quiet_busy", {31'h00000000, quiet_busy}, 32'h00000001);
    strobe(24'h000042, 8'h00, 1'b0);
    take(32'h00000042);
    rchk(8'h21, 8'h00);
    rchk(8'h1D, 8'h80);
    rchk(8'h34, 8'h01);
    end_of_test;
  end
endmodule
